/* verification/bus_master_model.sv */
module bus_master_model #(
  parameter int RESET_CYC = 1000
) (
  input wire logic sys_clk,
  input wire logic dq,
  output logic masterLow
);
  timeunit 1ns;
  timeprecision 1ns;

  // line released from time zero so idle level comes from the pullup
  initial masterLow = 1'b0;

  // -------------------------------------------
  // slot generators
  // -------------------------------------------
  task automatic pause(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : pause

  // no strong pullup: slave runs on its own supply
  // so the master can poll status with read slots while work goes on
  // master opens slot; a zero stays low past the 601-cycle sample
  task automatic write_bit(input logic b);
    masterLow = 1'b1;
    pause(b ? 20 : 605);
    masterLow = 1'b0;
    pause(b ? 590 : 5);
  endtask : write_bit

  task automatic write_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      write_bit(v[i]);
    end
  endtask : write_byte

  // sample early: a zero is only held about 15 us
  task automatic read_bit(output logic b);
    masterLow = 1'b1;
    pause(20);
    masterLow = 1'b0;
    pause(180);
    b = dq;
    pause(110);
  endtask : read_bit

  task automatic read_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      read_bit(v[i]);
    end
  endtask : read_byte

  task automatic bus_reset(output logic pres);
    masterLow = 1'b1;
    pause(RESET_CYC + 10);
    masterLow = 1'b0;
    pause(1200);
    pres = dq;
    pause(1850);
  endtask : bus_reset
endmodule : bus_master_model

/* verification/thermometer_command_decoder_tb.sv */
module thermometer_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int RESET_CYC = 700;
  localparam logic [7:0] LOAD_CFG = 8'h1F;
  logic sysClk = 1'b0;
  logic rstN = 1'b0;
  logic dq, masterLow, dqOut, dqOe, convStart, alarmSearchGo, alarmFlag, b;
  logic parasitePowered = 1'b0;
  logic convDone = 1'b0;
  logic [15:0] convResult = 16'h0300;
  logic [1:0] convResolution;
  logic [7:0] v;
  logic [7:0] expDump [9] = '{8'h00, 8'h03, 8'h25, 8'hF1,
    (LOAD_CFG & therm_pkg::CFG_RES_MASK) | therm_pkg::CFG_FIXED_ONES,
    8'hFF, 8'hFF, 8'hFF, 8'hA5};
  int nMismatch = 0;
  int samplesChecked = 0;
  int convStarts = 0;
  int searchGos = 0;

  // long reset threshold stays above the roughly 30 us write-zero low time
  always #25 sysClk = ~sysClk;
  assign dq = ~((dqOe & ~dqOut) | masterLow);

  thermometer_command_decoder #(.RESET_LOW_CYCLES(RESET_CYC), .NV_COMMIT_CYCLES(50))
    i_thermometer_command_decoder (.sys_clk(sysClk), .rst_n(rstN), .dqIn(dq),
    .dqOut(dqOut), .dqOe(dqOe), .parasitePowered(parasitePowered), .convDone(convDone),
    .convResult(convResult), .scratchpadCrc(8'hA5), .convStart(convStart),
    .convResolution(convResolution), .alarmSearchGo(alarmSearchGo), .alarmFlag(alarmFlag));

  bus_master_model #(.RESET_CYC(RESET_CYC)) i_bus_master_model (.sys_clk(sysClk), .dq(dq),
    .masterLow(masterLow));

  // count start pulses, one expected per convert command
  always @(posedge sysClk) begin
    if (convStart === 1'b1) convStarts++;
    if (alarmSearchGo === 1'b1) searchGos++;
  end

  // -------------------------------------------
  // compare and closing tasks
  // -------------------------------------------
  task automatic check_bit(input logic got, input logic exp, input string msg);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check_bit

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask : check_byte

  task automatic tallyAndFinish;
    $display("mismatches %0d, checks %0d", nMismatch, samplesChecked);
    if (nMismatch == 0 && samplesChecked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tallyAndFinish

  task automatic select(input logic [7:0] cmd);
    i_bus_master_model.bus_reset(b);
    check_bit(b, 1'b0, "presence");
    i_bus_master_model.write_byte(therm_pkg::CMD_SKIP_ROM);
    i_bus_master_model.write_byte(cmd);
  endtask : select

  // -------------------------------------------
  // test sequence
  // -------------------------------------------
  initial begin
    repeat (3) @(posedge sysClk);
    #1 rstN = 1'b1;
    check_byte({6'h00, convResolution}, 8'h03, "power-up config");
    select(therm_pkg::CMD_LOAD);
    i_bus_master_model.write_byte(8'h25);
    i_bus_master_model.write_byte(8'hF1);
    i_bus_master_model.write_byte(LOAD_CFG);
    check_byte({6'h00, convResolution}, 8'h00, "resolution");
    select(therm_pkg::CMD_CONVERT);
    check_bit(convStarts == 1, 1'b1, "start pulse");
    i_bus_master_model.read_bit(b);
    check_bit(b, 1'b0, "busy status");
    convDone = 1'b1;
    @(posedge sysClk);
    #1 convDone = 1'b0;
    i_bus_master_model.read_bit(b);
    check_bit(b, 1'b1, "done status");
    check_bit(alarmFlag, 1'b1, "alarm above limit");
    select(therm_pkg::CMD_DUMP);
    for (int i = 0; i < 9; i++) begin
      i_bus_master_model.read_byte(v);
      check_byte(v, expDump[i], "dump byte");
    end
    // abandon a second dump after one byte, then query supply mode
    select(therm_pkg::CMD_DUMP);
    i_bus_master_model.read_byte(v);
    check_byte(v, expDump[0], "partial dump");
    parasitePowered = 1'b1;
    select(therm_pkg::CMD_SUPPLY);
    i_bus_master_model.read_bit(b);
    check_bit(b, 1'b0, "parasite supply");
    check_bit(dqOut, 1'b0, "open drain level");
    check_bit(searchGos == 0, 1'b1, "search without command");
    tallyAndFinish();
  end

  // watchdog a little beyond the roughly 108k cycles the sequence needs
  initial begin
    repeat (120000) @(posedge sysClk);
    nMismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    tallyAndFinish();
  end
endmodule : thermometer_command_decoder_tb

/* verilog/byte_fifo.sv */
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  // depth must be a power of two: pointers wrap by overflow
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } fifo_s;

  fifo_s r;
  fifo_s next_r;
  logic doPush;
  logic doPop;

  // honest flags straight from the count
  assign inReady = r.count != (AW+1)'(DEPTH);
  assign outValid = r.count != '0;
  assign outData = r.mem[r.rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outReady && outValid;

  // flush drops everything, a new transfer must not see stale bytes
  always_comb begin
    next_r = r;
    if (flush) begin
      next_r.wrPtr = '0;
      next_r.rdPtr = '0;
      next_r.count = '0;
    end else begin
      if (doPush) begin
        next_r.mem[r.wrPtr] = inData;
        next_r.wrPtr = r.wrPtr + AW'(1);
      end
      if (doPop) begin
        next_r.rdPtr = r.rdPtr + AW'(1);
      end
      if (doPush && !doPop) begin
        next_r.count = r.count + (AW+1)'(1);
      end else if (doPop && !doPush) begin
        next_r.count = r.count - (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule : byte_fifo

/* verilog/therm_pkg.sv */
package therm_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  // least times round up, chosen mid-window times round up as well
  localparam int RESET_LOW_NS = 480_000;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int PRES_WAIT_NS = 30_000;
  localparam int PRES_WAIT_CYC = (PRES_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int PRES_LOW_NS = 120_000;
  localparam int PRES_LOW_CYC = (PRES_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int WRITE_SAMPLE_NS = 30_000;
  localparam int WRITE_SAMPLE_CYC = (WRITE_SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_VALID_NS = 15_000;
  localparam int READ_VALID_CYC = (READ_VALID_NS * CLK_MHZ + 999) / 1000;
  localparam int NV_COMMIT_NS = 10_000_000;
  localparam int NV_COMMIT_CYC = (NV_COMMIT_NS / 1000) * CLK_MHZ;
  localparam int RESTORE_NS = 10_000;
  localparam int RESTORE_CYC = (RESTORE_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SKIP_ROM = 8'hCC;
  localparam logic [7:0] CMD_ALARM_SEARCH = 8'hEC;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_LOAD = 8'h4E;
  localparam logic [7:0] CMD_DUMP = 8'hBE;
  localparam logic [7:0] CMD_COMMIT = 8'h48;
  localparam logic [7:0] CMD_RESTORE = 8'hB8;
  localparam logic [7:0] CMD_SUPPLY = 8'hB4;

  // ----------------------------------------------------------------
  // scratchpad layout and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_TEMP_LSB = 4'h0;
  localparam logic [3:0] OFS_TEMP_MSB = 4'h1;
  localparam logic [3:0] OFS_HIGH = 4'h2;
  localparam logic [3:0] OFS_LOW = 4'h3;
  localparam logic [3:0] OFS_CFG = 4'h4;
  localparam logic [3:0] OFS_CRC = 4'h8;
  localparam logic [7:0] RSVD_BYTE = 8'hFF;
  localparam logic [7:0] CFG_RES_MASK = 8'h60;
  localparam logic [7:0] CFG_FIXED_ONES = 8'h1F;
  localparam int CFG_RES_LSB = 5;
  localparam logic [7:0] NV_HIGH_RST = 8'h7F;
  localparam logic [7:0] NV_LOW_RST = 8'h80;
  localparam logic [7:0] NV_CFG_RST = 8'h7F;
  localparam logic [15:0] TEMP_RST = 16'h0000;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W = 8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PRES_WAIT, ST_PRES_DRIVE, ST_ROM_CMD, ST_FUNC_CMD, ST_LOAD,
    ST_DUMP, ST_CONV_STATUS, ST_NV_STATUS, ST_SUPPLY, ST_ALARM_SEARCH, ST_HOLD
  } state_e;

endpackage : therm_pkg

/* verilog/thermometer_command_decoder.sv */
module thermometer_command_decoder #(
  parameter int RESET_LOW_CYCLES = therm_pkg::RESET_LOW_CYC,
  parameter int NV_COMMIT_CYCLES = therm_pkg::NV_COMMIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dqIn,
  output logic dqOut,
  output logic dqOe,
  input wire logic parasitePowered,
  input wire logic convDone,
  input wire logic [15:0] convResult,
  input wire logic [7:0] scratchpadCrc,
  output logic convStart,
  output logic [1:0] convResolution,
  output logic alarmSearchGo,
  output logic alarmFlag
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    therm_pkg::state_e st;
    logic dqPrev;
    logic drive;
    logic pinLevel;
    logic inSlot;
    logic [13:0] slotCnt;
    logic [13:0] lowCnt;
    logic resetSeen;
    logic [11:0] presCnt;
    logic [7:0] shiftReg;
    logic [2:0] bitIdx;
    logic [3:0] loadIdx;
    logic [1:0] loadByte;
    logic [15:0] temperatureResult;
    logic [7:0] alarmHighLimit;
    logic [7:0] alarmLowLimit;
    logic [7:0] resolutionConfig;
    logic [2:0][7:0] nvMem;
    logic convBusy;
    logic commitBusy;
    logic restoreBusy;
    logic [27:0] nvCnt;
    logic alarm;
    logic convStart;
    logic searchGo;
  } state_s;

  state_s r;
  state_s next_r;
  logic fall;
  logic sampleNow;
  logic releaseNow;
  logic rxMode;
  logic txMode;
  logic txBit;
  logic byteDone;
  logic [7:0] rxByte;
  logic fifoPush;
  logic fifoPop;
  logic fifoFlush;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] pushData;
  logic [7:0] fifoOutData;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] padByte(input logic [3:0] idx, input state_s s,
                                         input logic [7:0] crc);
    logic [7:0] b;
    b = therm_pkg::RSVD_BYTE;
    if (idx == therm_pkg::OFS_TEMP_LSB) begin
      b = s.temperatureResult[7:0];
    end else if (idx == therm_pkg::OFS_TEMP_MSB) begin
      b = s.temperatureResult[15:8];
    end else if (idx == therm_pkg::OFS_HIGH) begin
      b = s.alarmHighLimit;
    end else if (idx == therm_pkg::OFS_LOW) begin
      b = s.alarmLowLimit;
    end else if (idx == therm_pkg::OFS_CFG) begin
      b = s.resolutionConfig;
    end else if (idx == therm_pkg::OFS_CRC) begin
      b = crc;
    end
    return b;
  endfunction : padByte

  // integer degrees sit in bits 11:4, compared signed against the limits
  function automatic logic alarmCheck(input logic [15:0] t, input logic [7:0] hi,
                                      input logic [7:0] lo);
    logic signed [7:0] deg;
    deg = $signed(t[11:4]);
    return (deg >= $signed(hi)) || (deg <= $signed(lo));
  endfunction : alarmCheck

  // ----------------------------------------------------------------
  // transmit buffer: the loader stalls on inReady, the slots drain it
  // ----------------------------------------------------------------
  byte_fifo #(
    .WIDTH(therm_pkg::BYTE_W),
    .DEPTH(therm_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .flush(fifoFlush),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(pushData),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  // ----------------------------------------------------------------
  // slot decode
  // ----------------------------------------------------------------
  // slots from master: our own pulldown never counts as a slot start
  assign fall = r.dqPrev && !dqIn && !r.drive;
  assign sampleNow = r.inSlot && (r.slotCnt == 14'(therm_pkg::WRITE_SAMPLE_CYC));
  assign releaseNow = r.inSlot && (r.slotCnt == 14'(therm_pkg::READ_VALID_CYC));
  assign rxMode = (r.st == therm_pkg::ST_ROM_CMD) || (r.st == therm_pkg::ST_FUNC_CMD) ||
                  (r.st == therm_pkg::ST_LOAD);
  assign txMode = (r.st == therm_pkg::ST_DUMP) || (r.st == therm_pkg::ST_CONV_STATUS) ||
                  (r.st == therm_pkg::ST_NV_STATUS) || (r.st == therm_pkg::ST_SUPPLY);
  // lsb first: new bit enters at the top and shifts down
  assign rxByte = {dqIn, r.shiftReg[7:1]};
  assign byteDone = rxMode && sampleNow && (r.bitIdx == 3'h7);

  // bit answered in the current read slot
  always_comb begin
    case (r.st)
      therm_pkg::ST_DUMP: txBit = fifoOutValid ? fifoOutData[r.bitIdx] : 1'b1;
      therm_pkg::ST_CONV_STATUS: txBit = !r.convBusy;
      therm_pkg::ST_NV_STATUS: txBit = !r.restoreBusy;
      therm_pkg::ST_SUPPLY: txBit = !parasitePowered;
      default: txBit = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.convStart = 1'b0;
    next_r.searchGo = 1'b0;
    next_r.dqPrev = dqIn;
    fifoPush = 1'b0;
    fifoPop = 1'b0;
    fifoFlush = 1'b0;
    pushData = padByte(r.loadIdx, r, scratchpadCrc);

    // reset detector saturates rather than wraps on a stuck-low line;
    // a read-zero pulldown still counts, or a reset over it would be missed
    if (!dqIn && !(r.drive && r.st == therm_pkg::ST_PRES_DRIVE)) begin
      if (r.lowCnt != 14'h3FFF) begin
        next_r.lowCnt = r.lowCnt + 14'h1;
      end
      if (r.lowCnt >= 14'(RESET_LOW_CYCLES - 1)) begin
        next_r.resetSeen = 1'b1;
      end
    end else begin
      next_r.lowCnt = 14'h0;
    end

    // slot timer runs from the master's falling edge
    if (fall) begin
      next_r.inSlot = 1'b1;
      next_r.slotCnt = 14'h0;
    end else if (sampleNow) begin
      next_r.inSlot = 1'b0;
    end else if (r.inSlot) begin
      next_r.slotCnt = r.slotCnt + 14'h1;
    end

    // conversion result lands, alarm judged against current limits
    if (convDone && r.convBusy) begin
      next_r.convBusy = 1'b0;
      next_r.temperatureResult = convResult;
      next_r.alarm = alarmCheck(convResult, r.alarmHighLimit, r.alarmLowLimit);
    end

    // nonvolatile timers; a bus reset does not cut a write short
    if (r.commitBusy || r.restoreBusy) begin
      next_r.nvCnt = r.nvCnt + 28'h1;
      if (r.commitBusy && r.nvCnt == 28'(NV_COMMIT_CYCLES - 1)) begin
        next_r.commitBusy = 1'b0;
      end
      if (r.restoreBusy && r.nvCnt == 28'(therm_pkg::RESTORE_CYC - 1)) begin
        next_r.restoreBusy = 1'b0;
        next_r.alarmHighLimit = r.nvMem[0];
        next_r.alarmLowLimit = r.nvMem[1];
        next_r.resolutionConfig = r.nvMem[2];
      end
    end

    // receive shift register
    if (rxMode && sampleNow) begin
      next_r.shiftReg = rxByte;
      next_r.bitIdx = r.bitIdx + 3'h1;
    end

    // read slot: pull low for a zero, release after valid time
    if (txMode && fall && !txBit) begin
      next_r.drive = 1'b1;
    end
    if (txMode && releaseNow) begin
      next_r.drive = 1'b0;
      if (r.st == therm_pkg::ST_DUMP) begin
        next_r.bitIdx = r.bitIdx + 3'h1;
        fifoPop = (r.bitIdx == 3'h7) && fifoOutValid;
      end
    end

    case (r.st)
      therm_pkg::ST_PRES_WAIT: begin
        next_r.presCnt = r.presCnt + 12'h1;
        if (r.presCnt == 12'(therm_pkg::PRES_WAIT_CYC - 1)) begin
          next_r.presCnt = 12'h0;
          next_r.drive = 1'b1;
          next_r.st = therm_pkg::ST_PRES_DRIVE;
        end
      end
      therm_pkg::ST_PRES_DRIVE: begin
        next_r.presCnt = r.presCnt + 12'h1;
        if (r.presCnt == 12'(therm_pkg::PRES_LOW_CYC - 1)) begin
          next_r.drive = 1'b0;
          next_r.bitIdx = 3'h0;
          next_r.st = therm_pkg::ST_ROM_CMD;
        end
      end
      therm_pkg::ST_ROM_CMD: begin
        if (byteDone) begin
          // only skip ROM opens the function layer
          if (rxByte == therm_pkg::CMD_SKIP_ROM) begin
            next_r.st = therm_pkg::ST_FUNC_CMD;
          end else if (rxByte == therm_pkg::CMD_ALARM_SEARCH && r.alarm) begin
            next_r.searchGo = 1'b1;
            next_r.st = therm_pkg::ST_ALARM_SEARCH;
          end else begin
            next_r.st = therm_pkg::ST_HOLD;
          end
        end
      end
      therm_pkg::ST_FUNC_CMD: begin
        if (byteDone) begin
          if (rxByte == therm_pkg::CMD_CONVERT) begin
            next_r.convStart = 1'b1;
            next_r.convBusy = 1'b1;
            next_r.st = therm_pkg::ST_CONV_STATUS;
          end else if (rxByte == therm_pkg::CMD_LOAD) begin
            next_r.loadByte = 2'h0;
            next_r.st = therm_pkg::ST_LOAD;
          end else if (rxByte == therm_pkg::CMD_DUMP) begin
            next_r.loadIdx = 4'h0;
            next_r.st = therm_pkg::ST_DUMP;
          end else if (rxByte == therm_pkg::CMD_COMMIT) begin
            // snapshot the three bytes, then time the write
            next_r.nvMem = {r.resolutionConfig, r.alarmLowLimit, r.alarmHighLimit};
            next_r.commitBusy = 1'b1;
            next_r.nvCnt = 28'h0;
            next_r.st = therm_pkg::ST_HOLD;
          end else if (rxByte == therm_pkg::CMD_RESTORE) begin
            next_r.restoreBusy = 1'b1;
            next_r.nvCnt = 28'h0;
            next_r.st = therm_pkg::ST_NV_STATUS;
          end else if (rxByte == therm_pkg::CMD_SUPPLY) begin
            next_r.st = therm_pkg::ST_SUPPLY;
          end else begin
            next_r.st = therm_pkg::ST_HOLD;
          end
        end
      end
      therm_pkg::ST_LOAD: begin
        // three bytes in fixed order; fixed config bits kept
        if (byteDone) begin
          next_r.loadByte = r.loadByte + 2'h1;
          if (r.loadByte == 2'h0) begin
            next_r.alarmHighLimit = rxByte;
          end else if (r.loadByte == 2'h1) begin
            next_r.alarmLowLimit = rxByte;
          end else begin
            next_r.resolutionConfig = (rxByte & therm_pkg::CFG_RES_MASK) |
                                      therm_pkg::CFG_FIXED_ONES;
            next_r.st = therm_pkg::ST_HOLD;
          end
        end
      end
      therm_pkg::ST_DUMP: begin
        // bytes 0 to 8 in order, loader stalls while full
        if (r.loadIdx <= therm_pkg::OFS_CRC) begin
          fifoPush = 1'b1;
          if (fifoInReady) begin
            next_r.loadIdx = r.loadIdx + 4'h1;
          end
        end
      end
      default: begin
      end
    endcase

    // reset ends the bus transaction under way and restarts initialisation
    if (r.resetSeen && dqIn) begin
      fifoFlush = 1'b1;
      fifoPush = 1'b0;
      fifoPop = 1'b0;
      next_r.resetSeen = 1'b0;
      next_r.drive = 1'b0;
      next_r.inSlot = 1'b0;
      next_r.bitIdx = 3'h0;
      next_r.shiftReg = 8'h00;
      next_r.presCnt = 12'h0;
      next_r.st = therm_pkg::ST_PRES_WAIT;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // power-up comes out with a restore already running
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= therm_pkg::ST_IDLE;
      r.dqPrev <= 1'b1;
      r.temperatureResult <= therm_pkg::TEMP_RST;
      r.alarmHighLimit <= therm_pkg::NV_HIGH_RST;
      r.alarmLowLimit <= therm_pkg::NV_LOW_RST;
      r.resolutionConfig <= therm_pkg::NV_CFG_RST;
      r.nvMem <= {therm_pkg::NV_CFG_RST, therm_pkg::NV_LOW_RST, therm_pkg::NV_HIGH_RST};
      r.restoreBusy <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign dqOut = r.pinLevel;
  assign dqOe = r.drive;
  assign convStart = r.convStart;
  assign convResolution = r.resolutionConfig[therm_pkg::CFG_RES_LSB +: 2];
  assign alarmSearchGo = r.searchGo;
  assign alarmFlag = r.alarm;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [13:0] driveLen;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      driveLen <= 14'h0;
    end else begin
      driveLen <= dqOe ? driveLen + 14'h1 : 14'h0;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  presence_drive_a: assert property (r.st == therm_pkg::ST_PRES_DRIVE |-> dqOe)
    else $error("presence state without pulldown");
  presence_len_a: assert property (
    $fell(dqOe) && $past(r.st) == therm_pkg::ST_PRES_DRIVE
      |-> driveLen == 14'(therm_pkg::PRES_LOW_CYC))
    else $error("presence pulse length wrong");
  read_release_a: assert property (
    txMode && releaseNow && !(r.resetSeen && dqIn) |=> !dqOe)
    else $error("read zero not released after valid time");
  sample_bit_a: assert property (
    rxMode && sampleNow && !(r.resetSeen && dqIn) |=> r.shiftReg[7] == $past(dqIn))
    else $error("write slot bit not taken at sampling point");
  skip_select_a: assert property (
    byteDone && r.st == therm_pkg::ST_ROM_CMD && rxByte == therm_pkg::CMD_SKIP_ROM
      && !r.resetSeen |=> r.st == therm_pkg::ST_FUNC_CMD)
    else $error("skip ROM did not select");
  alarm_silent_a: assert property (
    byteDone && r.st == therm_pkg::ST_ROM_CMD && rxByte == therm_pkg::CMD_ALARM_SEARCH
      && !r.alarm && !r.resetSeen |=> r.st == therm_pkg::ST_HOLD && !alarmSearchGo)
    else $error("alarm search answered without alarm");
  conv_start_a: assert property (convStart |-> r.convBusy && $past(r.st) == therm_pkg::ST_FUNC_CMD)
    else $error("conversion start out of sequence");
  conv_status_a: assert property (
    r.st == therm_pkg::ST_CONV_STATUS && fall && !r.resetSeen
      |=> dqOe == $past(r.convBusy))
    else $error("conversion status bit wrong");
  supply_answer_a: assert property (
    r.st == therm_pkg::ST_SUPPLY && fall && !r.resetSeen |=> dqOe == $past(parasitePowered))
    else $error("supply query answer wrong");
  reset_abort_a: assert property (
    r.resetSeen && dqIn |=> r.st == therm_pkg::ST_PRES_WAIT && !dqOe)
    else $error("reset did not restart initialisation");
  func_entry_a: assert property (
    $rose(r.st == therm_pkg::ST_FUNC_CMD) |-> $past(r.st) == therm_pkg::ST_ROM_CMD)
    else $error("function layer entered without ROM command");

endmodule : thermometer_command_decoder
